// ==== tws_two_wire.sv ====
`timescale 1ns/1ps
`default_nettype none
module tws_two_wire
  import tws_pkg::*;
(
  // core clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // link sampling clock
  input wire logic link_clk,
  // special function register port
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic bit_wr,
  input wire logic [2:0] bit_sel,
  input wire logic bit_val,
  // request line shared with the other serial block
  output logic irq,
  // serial pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe
);
  import tws_pkg::*;

  tws_ctl_s two_wire_control;
  logic [7:0] first_slave_address;
  logic [7:0] second_slave_address;
  logic [7:0] two_wire_data_reg;
  logic pend;
  logic req_s1, req_s2, req_s3, ack_t, rel_t;
  logic cs1, cs2, cs3, cd1, cd2;
  logic req_t, ack_s1, ack_s2, ack_s3, rel_s1, rel_s2, rel_s3;
  logic hold_c, hold_s1, hold_s2;
  logic [7:0] sa1_s1, sa1_s2, sa2_s1, sa2_s2;
  logic ls1, ls2, ls3, ld1, ld2, ld3;
  tws_word_s xfer_hold;
  tws_state_e state;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic rw, sda_lo, scl_lo, busy;
  logic dat_acc, got_word, release_evt, scl_rise_c;
  logic start_c, stop_c, rise_l, fall_l, match_l, link_hold;
  tws_word_s buf_mem [TWS_BUF_DEPTH];
  logic [1:0] buf_cnt;
  logic buf_wp, buf_rp, in_valid, in_ready, out_valid, out_ready;

  assign dat_acc = (sfr_wr | sfr_rd) & (sfr_addr == TWS_ADDR_DAT);
  assign got_word = req_s2 ^ req_s3;

  // core-side pin synchronisers, used only by the soft master
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // idle bus level, so no false clock rise follows reset
      {cs1, cs2, cs3, cd1, cd2} <= '1;
    end
    else
    begin
      cs1 <= scl_i;
      cs2 <= cs1;
      cs3 <= cs2;
      cd1 <= serial_data_pin_i;
      cd2 <= cd1;
    end
  end
  assign scl_rise_c = cs2 & ~cs3;

  // control register: byte and single bit writes, hardware-owned bits kept
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      two_wire_control <= tws_ctl_s'(TWS_RST_CTL);
    end
    else
    begin
      if (sfr_wr && sfr_addr == TWS_ADDR_CTL)
      begin
        two_wire_control.soft_master_data_out <= sfr_wdata[7];
        two_wire_control.soft_master_data_drive_en <= sfr_wdata[6];
        two_wire_control.soft_master_clock_out <= sfr_wdata[5];
        two_wire_control.master_role_select <= sfr_wdata[3];
        two_wire_control.slave_soft_reset <= sfr_wdata[2];
      end
      else if (bit_wr)
      begin
        // bit access, the read-only bits 4, 1, 0 ignore it
        case (bit_sel)
          3'h7: two_wire_control.soft_master_data_out <= bit_val;
          3'h6: two_wire_control.soft_master_data_drive_en <= bit_val;
          3'h5: two_wire_control.soft_master_clock_out <= bit_val;
          3'h3: two_wire_control.master_role_select <= bit_val;
          3'h2: two_wire_control.slave_soft_reset <= bit_val;
          default: ;
        endcase
      end
      // data pin sampled at a clock rise while undriven
      if (two_wire_control.master_role_select && !two_wire_control.soft_master_data_drive_en
          && scl_rise_c)
        two_wire_control.soft_master_data_in <= cd2;
      // a new byte sets the flag; set wins over the access that clears it
      if (two_wire_control.slave_soft_reset)
        two_wire_control.transfer_done_flag <= 1'b0;
      else if (got_word)
        two_wire_control.transfer_done_flag <= 1'b1;
      else if (dat_acc)
        two_wire_control.transfer_done_flag <= 1'b0;
      if (got_word)
        two_wire_control.slave_direction <= xfer_hold.dir;
    end
  end

  // address registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      first_slave_address <= TWS_RST_SA1;
      second_slave_address <= TWS_RST_SA2;
    end
    else if (sfr_wr)
    begin
      if (sfr_addr == TWS_ADDR_SA1)
        first_slave_address <= sfr_wdata;
      if (sfr_addr == TWS_ADDR_SA2)
        second_slave_address <= sfr_wdata;
    end
  end

  // data register; the byte it holds is also what a release sends out
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      two_wire_data_reg <= TWS_RST_DAT;
    else if (got_word)
      two_wire_data_reg <= xfer_hold.data;
    else if (sfr_wr && sfr_addr == TWS_ADDR_DAT)
      two_wire_data_reg <= sfr_wdata;
  end

  // crossing from link: toggle request, capture the held word, toggle ack;
  // the first data access after a capture toggles the release to the link
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {req_s1, req_s2, req_s3, ack_t, rel_t, pend} <= '0;
      hold_c <= 1'b1;
    end
    else
    begin
      req_s1 <= req_t;
      req_s2 <= req_s1;
      req_s3 <= req_s2;
      // registered before the crossing so no gate glitch reaches the link side
      hold_c <= two_wire_control.slave_soft_reset | two_wire_control.master_role_select;
      if (got_word)
      begin
        ack_t <= ~ack_t;
        pend <= 1'b1;
      end
      else if (pend && dat_acc)
      begin
        pend <= 1'b0;
        rel_t <= ~rel_t;
      end
    end
  end

  // read mux, unmapped addresses read zero
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sfr_rdata <= '0;
    else if (sfr_rd)
    begin
      case (sfr_addr)
        TWS_ADDR_CTL: sfr_rdata <= two_wire_control;
        TWS_ADDR_SA1: sfr_rdata <= first_slave_address;
        TWS_ADDR_SA2: sfr_rdata <= second_slave_address;
        TWS_ADDR_DAT: sfr_rdata <= two_wire_data_reg;
        default: sfr_rdata <= '0;
      endcase
    end
  end

  // the vector is shared, so the handler must poll this flag too
  assign irq = two_wire_control.transfer_done_flag;

  // pins are dedicated to this block, no function mux in between
  // in slave mode only the slave engine reaches the pins
  always_comb
  begin
    if (two_wire_control.master_role_select)
    begin
      serial_data_pin_o = two_wire_control.soft_master_data_out;
      serial_data_pin_oe = two_wire_control.soft_master_data_drive_en;
      scl_o = two_wire_control.soft_master_clock_out;
      scl_oe = 1'b1;
    end
    else
    begin
      serial_data_pin_o = 1'b0;
      serial_data_pin_oe = sda_lo;
      scl_o = 1'b0;
      scl_oe = scl_lo;
    end
  end

  // link-side synchronisers; addresses are quasi-static, change them in reset
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      // idle bus level, so no false edge or start follows reset
      {ls1, ls2, ls3, ld1, ld2, ld3} <= '1;
      {ack_s1, ack_s2, ack_s3, rel_s1, rel_s2, rel_s3} <= '0;
      {hold_s1, hold_s2} <= 2'b11;
      {sa1_s1, sa1_s2, sa2_s1, sa2_s2} <= '0;
    end
    else
    begin
      ls1 <= scl_i;
      ls2 <= ls1;
      ls3 <= ls2;
      ld1 <= serial_data_pin_i;
      ld2 <= ld1;
      ld3 <= ld2;
      ack_s1 <= ack_t;
      ack_s2 <= ack_s1;
      ack_s3 <= ack_s2;
      rel_s1 <= rel_t;
      rel_s2 <= rel_s1;
      rel_s3 <= rel_s2;
      hold_s1 <= hold_c;
      hold_s2 <= hold_s1;
      sa1_s1 <= first_slave_address;
      sa1_s2 <= sa1_s1;
      sa2_s1 <= second_slave_address;
      sa2_s2 <= sa2_s1;
    end
  end

  assign link_hold = hold_s2;
  assign start_c = ls3 & ls2 & ld3 & ~ld2;
  assign stop_c = ls3 & ls2 & ~ld3 & ld2;
  assign rise_l = ~ls3 & ls2;
  assign fall_l = ls3 & ~ls2;
  assign release_evt = rel_s2 ^ rel_s3;
  assign match_l = (shreg[7:1] == sa1_s2[6:0]) | (shreg[7:1] == sa2_s2[6:0]);
  assign in_valid = (state == TWS_POST);

  // slave engine on the link clock
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= TWS_IDLE;
      {cnt, shreg, rw, sda_lo, scl_lo} <= '0;
    end
    else if (link_hold || stop_c)
    begin
      state <= TWS_IDLE;
      {sda_lo, scl_lo} <= '0;
    end
    else if (start_c)
    begin
      state <= TWS_ADDR;
      cnt <= '0;
      sda_lo <= 1'b0;
    end
    else
    begin
      case (state)
        TWS_ADDR, TWS_RX:
        begin
          if (rise_l && cnt != TWS_BITS)
          begin
            shreg <= {shreg[6:0], ld2};
            cnt <= cnt + 4'h1;
          end
          else if (fall_l && cnt == TWS_BITS)
          begin
            if (state == TWS_RX || match_l)
            begin
              if (state == TWS_ADDR)
                rw <= shreg[0];
              sda_lo <= 1'b1;
              state <= TWS_ACK;
            end
            else
              state <= TWS_IDLE;
          end
        end
        TWS_ACK:
          if (fall_l)
          begin
            sda_lo <= 1'b0;
            scl_lo <= 1'b1;
            state <= TWS_POST;
          end
        TWS_POST:
          if (in_ready)
            state <= TWS_HOLD;
        TWS_HOLD:
          if (release_evt)
          begin
            scl_lo <= 1'b0;
            if (rw)
            begin
              shreg <= two_wire_data_reg; // stable while the link holds
              sda_lo <= ~two_wire_data_reg[7];
              cnt <= 4'h1;
              state <= TWS_TX;
            end
            else
            begin
              cnt <= '0;
              state <= TWS_RX;
            end
          end
        TWS_TX:
          if (fall_l)
          begin
            if (cnt == TWS_BITS)
            begin
              sda_lo <= 1'b0;
              state <= TWS_CHK;
            end
            else
            begin
              sda_lo <= ~shreg[6];
              shreg <= {shreg[6:0], 1'b0};
              cnt <= cnt + 4'h1;
            end
          end
        TWS_CHK:
          if (rise_l && ld2)
            state <= TWS_IDLE;
          else if (fall_l)
          begin
            scl_lo <= 1'b1;
            state <= TWS_POST;
          end
        default: state <= TWS_IDLE;
      endcase
    end
  end

  // two-entry buffer; a full buffer keeps the engine in post with the clock held
  assign in_ready = (buf_cnt != 2'(TWS_BUF_DEPTH));
  assign out_valid = (buf_cnt != 2'h0);
  assign out_ready = ~busy;
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {buf_cnt, buf_wp, buf_rp} <= '0;
      for (int i = 0; i < TWS_BUF_DEPTH; i++)
        buf_mem[i] <= '0;
    end
    else if (link_hold)
      {buf_cnt, buf_wp, buf_rp} <= '0;
    else
    begin
      if (in_valid && in_ready)
      begin
        buf_mem[buf_wp] <= '{dir: rw, data: shreg};
        buf_wp <= ~buf_wp;
      end
      if (out_valid && out_ready)
        buf_rp <= ~buf_rp;
      buf_cnt <= buf_cnt + 2'(in_valid && in_ready) - 2'(out_valid && out_ready);
    end
  end

  // word toward the core: hold steady, toggle request, wait for ack edge
  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      xfer_hold <= '0;
      {req_t, busy} <= '0;
    end
    else if (out_valid && out_ready)
    begin
      xfer_hold <= buf_mem[buf_rp];
      req_t <= ~req_t;
      busy <= 1'b1;
    end
    else if (ack_s2 ^ ack_s3)
      busy <= 1'b0;
  end
endmodule : tws_two_wire
`default_nettype wire

// ==== tws_pkg.sv ====
package tws_pkg;
  // special function addresses
  localparam logic [7:0] TWS_ADDR_CTL = 8'hE8;
  localparam logic [7:0] TWS_ADDR_SA1 = 8'h9B;
  localparam logic [7:0] TWS_ADDR_SA2 = 8'hF2;
  localparam logic [7:0] TWS_ADDR_DAT = 8'h9A;
  // power-on values
  localparam logic [7:0] TWS_RST_CTL = 8'h00;
  localparam logic [7:0] TWS_RST_SA1 = 8'h55;
  localparam logic [7:0] TWS_RST_SA2 = 8'h7F;
  localparam logic [7:0] TWS_RST_DAT = 8'h00;
  // bit count of one byte on the wire
  localparam logic [3:0] TWS_BITS = 4'h8;
  localparam int TWS_BUF_DEPTH = 2;

  // control register, bit 7 down to bit 0
  typedef struct packed {
    logic soft_master_data_out;
    logic soft_master_data_drive_en;
    logic soft_master_clock_out;
    logic soft_master_data_in;
    logic master_role_select;
    logic slave_soft_reset;
    logic slave_direction;
    logic transfer_done_flag;
  } tws_ctl_s;

  // one completed byte handed from the link to the core
  typedef struct packed {
    logic dir;
    logic [7:0] data;
  } tws_word_s;

  typedef enum logic [2:0] {
    TWS_IDLE = 3'b000,
    TWS_ADDR = 3'b001,
    TWS_RX = 3'b010,
    TWS_ACK = 3'b011,
    TWS_POST = 3'b100,
    TWS_HOLD = 3'b101,
    TWS_TX = 3'b110,
    TWS_CHK = 3'b111
  } tws_state_e;
endpackage : tws_pkg

// ==== tws_two_wire_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module tws_two_wire_chk
  import tws_pkg::*;
(
  // watched ports
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic bit_wr,
  input wire logic [2:0] bit_sel,
  input wire logic bit_val,
  input wire logic irq,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic serial_data_pin_o,
  input wire logic serial_data_pin_oe
);
  logic [7:0] c;
  logic [7:0] cq;
  logic hit;
  logic acc;
  assign hit = sfr_addr inside {TWS_ADDR_CTL, TWS_ADDR_SA1, TWS_ADDR_SA2, TWS_ADDR_DAT};
  assign acc = (sfr_rd || sfr_wr) && sfr_addr == TWS_ADDR_DAT;
  // shadow of the control bits; byte write beats bit write as in the design
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      c <= 8'h00;
    else if (sfr_wr && sfr_addr == TWS_ADDR_CTL)
      c <= sfr_wdata;
    else if (bit_wr)
      c[bit_sel] <= bit_val;
  // one-cycle copy, since read data lags the strobe
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      cq <= 8'h00;
    else
      cq <= c;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_scl_master: assert property (c[3] |-> scl_oe && scl_o == c[5])
    else $error("clock pin not following master clock bit");
  a_sda_master: assert property (c[3] |->
    serial_data_pin_oe == c[6] && (!c[6] || serial_data_pin_o == c[7]))
    else $error("data pin not following master bits");
  a_slave_quiet: assert property (!c[3] |-> !scl_o && !serial_data_pin_o)
    else $error("master bits leak in slave mode");
  a_stretch_hold: assert property (!c[3] && irq |-> scl_oe)
    else $error("clock not held while flag set");
  a_flag_clear: assert property (acc ##1 !acc |-> ##1 !irq)
    else $error("flag survives data access");
  a_unmapped_zero: assert property (sfr_rd && !hit |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without read");
  a_ctl_readback: assert property (sfr_rd && sfr_addr == TWS_ADDR_CTL |=>
    sfr_rdata[7:5] == cq[7:5] && sfr_rdata[3:2] == cq[3:2])
    else $error("control readback wrong");
endmodule : tws_two_wire_chk
bind tws_two_wire tws_two_wire_chk i_chk (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
  .bit_wr(bit_wr), .bit_sel(bit_sel), .bit_val(bit_val), .irq(irq), .scl_o(scl_o),
  .scl_oe(scl_oe), .serial_data_pin_o(serial_data_pin_o),
  .serial_data_pin_oe(serial_data_pin_oe));
`default_nettype wire

// ==== tws_bus_master.sv ====
`timescale 1ns/1ps
`default_nettype none
module tws_bus_master
(
  // resolved wire levels
  input wire logic scl,
  input wire logic sda,
  // open-drain pulls, 1 releases to the pull-up
  output var logic scl_pull,
  output var logic sda_pull
);
  localparam int T = 200;
  // bus idle: both lines released
  initial
  begin
    scl_pull = 1'b1;
    sda_pull = 1'b1;
  end
  // one clock; waits while the slave stretches, bounded so a stuck line ends
  task automatic clk_pulse(output logic b);
    int n;
    #T;
    scl_pull = 1'b1;
    n = 0;
    while (!scl && n < 5000)
    begin
      #10;
      n++;
    end
    #T;
    b = sda;
    scl_pull = 1'b0;
    #50;
  endtask : clk_pulse
  task automatic set_sda(input logic d);
    sda_pull = d;
  endtask : set_sda
  task automatic start_cond();
    sda_pull = 1'b0;
    #T;
    scl_pull = 1'b0;
    #50;
  endtask : start_cond
  task automatic stop_cond();
    int n;
    sda_pull = 1'b0;
    #T;
    scl_pull = 1'b1;
    n = 0;
    // a stretching slave must let go before the stop edge means anything
    while (!scl && n < 5000)
    begin
      #10;
      n++;
    end
    #T;
    sda_pull = 1'b1;
    #T;
  endtask : stop_cond
  // eight bits msb first, then the ninth clock with sda = last
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
    output logic ack_n);
    for (int i = 7; i >= 0; i--)
    begin
      sda_pull = d[i];
      clk_pulse(q[i]);
    end
    sda_pull = last;
    clk_pulse(ack_n);
    sda_pull = 1'b1;
  endtask : xfer
endmodule : tws_bus_master
`default_nettype wire

// ==== tws_two_wire_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tws_two_wire_tb_top;
  import tws_pkg::*;
  logic clk, arst_n, link_clk, wr, rd, bw, bv, irq, a;
  logic scl_o, scl_oe, sd_o, sd_oe, scl_p, sd_p;
  logic [7:0] ad, wd, rdat, q, mq;
  logic [2:0] bs;
  wire logic scl_w;
  wire logic sd_w;
  int failures, samples_checked, cycles;
  // open-drain wires with pull-ups
  assign scl_w = scl_p & ~(scl_oe & ~scl_o);
  assign sd_w = sd_p & ~(sd_oe & ~sd_o);
  tws_two_wire i_dut (.clk(clk), .arst_n(arst_n), .link_clk(link_clk), .sfr_addr(ad),
    .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wd), .sfr_rdata(rdat), .bit_wr(bw), .bit_sel(bs),
    .bit_val(bv), .irq(irq), .scl_i(scl_w), .scl_o(scl_o), .scl_oe(scl_oe),
    .serial_data_pin_i(sd_w), .serial_data_pin_o(sd_o), .serial_data_pin_oe(sd_oe));
  tws_bus_master i_mst (.scl(scl_w), .sda(sd_w), .scl_pull(scl_p), .sda_pull(sd_p));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // link clock unrelated in phase
  initial
  begin
    link_clk = 1'b0;
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  // a hang is cut short well above the few thousand cycles needed
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      failures++;
      end_of_test();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  // one register access; read data is taken a cycle after the strobe
  task automatic sfr(input logic r, input logic [7:0] adr, input logic [7:0] d);
    @(negedge clk);
    ad = adr;
    wd = d;
    rd = r;
    wr = !r;
    @(negedge clk);
    rd = 1'b0;
    wr = 1'b0;
    q = rdat;
  endtask : sfr
  task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
    sfr(1'b1, adr, 8'h00);
    check(q, exp);
  endtask : rd_chk
  task automatic bset(input logic [2:0] n, input logic v);
    @(negedge clk);
    bs = n;
    bv = v;
    bw = 1'b1;
    @(negedge clk);
    bw = 1'b0;
  endtask : bset
  task automatic addr_only(input logic [7:0] b, input logic exp_nack);
    i_mst.start_cond();
    i_mst.xfer(b, 1'b1, mq, a);
    check({7'h00, a}, {7'h00, exp_nack});
    i_mst.stop_cond();
  endtask : addr_only
  task automatic mw(input logic [7:0] d);
    i_mst.xfer(d, 1'b1, mq, a);
    check({7'h00, a}, 8'h00);
  endtask : mw
  task automatic mr(input logic [7:0] exp, input logic last);
    i_mst.xfer(8'hFF, last, mq, a);
    check(mq, exp);
  endtask : mr
  // firmware serving one flagged byte with a single data access
  task automatic fw(input logic [7:0] exp, input logic tx, input logic [7:0] nxt);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    rd_chk(TWS_ADDR_CTL, {6'h00, tx, 1'b1});
    if (tx)
      sfr(1'b0, TWS_ADDR_DAT, nxt);
    else
      rd_chk(TWS_ADDR_DAT, exp);
    rd_chk(TWS_ADDR_CTL, {6'h00, tx, 1'b0});
  endtask : fw
  initial
  begin
    {arst_n, wr, rd, bw, bv, bs, ad, wd} = '0;
    repeat (12) @(negedge clk);
    arst_n = 1'b1;
    repeat (8) @(negedge clk);
    rd_chk(TWS_ADDR_CTL, 8'h00);
    rd_chk(TWS_ADDR_SA1, 8'h55);
    rd_chk(TWS_ADDR_SA2, 8'h7F);
    rd_chk(TWS_ADDR_DAT, 8'h00);
    rd_chk(8'h00, 8'h00);
    sfr(1'b0, TWS_ADDR_CTL, 8'hEB);
    rd_chk(TWS_ADDR_CTL, 8'hE8);
    check({6'h00, scl_oe, scl_o}, 8'h03);
    check({6'h00, sd_oe, sd_o}, 8'h03);
    bset(3'h7, 1'b0);
    check({6'h00, sd_oe, sd_o}, 8'h02);
    bset(3'h6, 1'b0);
    check({7'h00, sd_oe}, 8'h00);
    for (int v = 1; v >= 0; v--)
    begin
      i_mst.set_sda(v[0]);
      bset(3'h5, 1'b0);
      bset(3'h5, 1'b1);
      repeat (10) @(negedge clk);
      rd_chk(TWS_ADDR_CTL, {3'b001, v[0], 4'h8});
    end
    i_mst.set_sda(1'b1);
    sfr(1'b0, TWS_ADDR_CTL, 8'h04);
    rd_chk(TWS_ADDR_CTL, 8'h04);
    sfr(1'b0, TWS_ADDR_SA2, 8'h21);
    rd_chk(TWS_ADDR_SA2, 8'h21);
    repeat (10) @(negedge clk);
    addr_only(8'h42, 1'b1);
    bset(3'h2, 1'b0);
    repeat (10) @(negedge clk);
    addr_only(8'h66, 1'b1);
    fork
      begin
        i_mst.start_cond();
        mw(8'hAA);
        mw(8'hA5);
        mw(8'h3C);
        i_mst.stop_cond();
      end
      begin
        fw(8'hAA, 1'b0, 8'h00);
        fw(8'hA5, 1'b0, 8'h00);
        fw(8'h3C, 1'b0, 8'h00);
      end
    join
    // after the stop a byte with no start must go unanswered
    i_mst.xfer(8'hAA, 1'b1, mq, a);
    check({7'h00, a}, 8'h01);
    i_mst.stop_cond();
    fork
      begin
        i_mst.start_cond();
        mw(8'h43);
        mr(8'hC3, 1'b0);
        mr(8'h5A, 1'b1);
        i_mst.stop_cond();
      end
      begin
        fw(8'h00, 1'b1, 8'hC3);
        fw(8'h00, 1'b1, 8'h5A);
      end
    join
    repeat (50) @(negedge clk);
    check({7'h00, irq}, 8'h00);
    end_of_test();
  end
endmodule : tws_two_wire_tb_top
`default_nettype wire
